/* pkg/pll_clock_and_reset_unit_consts.svh */
// Constants for the PLL clock and reset unit
//
// Contract
// R01: Each PLL runs at reference times feedback ratio, over input ratio, over output ratio.
// R02: Software picks an input ratio that keeps the divided reference at or above 1 MHz.
// R03: The input divider is five bits used directly as the ratio, valid only from 2 to 31.
// R04: The feedback divider is nine bits used directly as the ratio, valid only from 2 to 511.
// R05: Output divider codes 00, 01, 11 give ratios 1, 2, 4 and code 10 is unsupported.
// R06: The engine, memory and pixel PLLs run independently of each other.
// R07: Software keeps memory clock between engine and twice engine, engine over 1.5x pixel.
// R08: Power-on reset holds until power is stable, then releases after 256 reference cycles.
// R09: The power-on reset is driven out on the two-way reset pin.
// R10: An external reset is taken only after the pin stays low 256 reference cycles.
// R11: The host checks status bit 1 for normal operation before any access.
// R12: Writing 1 to bit 0 of the control register at offset zero starts a software reset.
// R13: A software reset restarts the state machines and leaves every register unchanged.
// R14: The software reset bit clears itself to 0 when the software reset completes.
// R15: A PLL output counts as unstable for up to 500 us after power-up or a change.
// R16: Status reports normal operation only after reset release and PLL lock time.
`ifndef PLL_CLOCK_AND_RESET_UNIT_CONSTS_SVH
`define PLL_CLOCK_AND_RESET_UNIT_CONSTS_SVH

// Register offsets
`define ADDR_CTRL 8'h00
`define ADDR_PIXEL_CFG1 8'h05
`define ADDR_PIXEL_CFG2 8'h06
`define ADDR_MEMORY_CFG1 8'h07
`define ADDR_MEMORY_CFG2 8'h08
`define ADDR_ENGINE_CFG1 8'h09
`define ADDR_ENGINE_CFG2 8'h0A

// Field positions
`define SWRST_BIT 0
`define CFG1_OUTDIV_HI 7
`define CFG1_OUTDIV_LO 6
`define CFG1_R_HI 5
`define CFG1_R_LO 1
`define CFG1_N8_BIT 0
`define STS_SOFT_BIT 0
`define STS_NORMAL_BIT 1
`define STS_CFGERR_BIT 2

// PLL indices, in offset order
`define PLL_PIXEL 0
`define PLL_MEMORY 1
`define PLL_ENGINE 2
`define PLL_COUNT 3

// Reset values
`define CTRL_RST 8'h00
`define CFG1_RST 8'h14
`define CFG2_RST 8'h0A

// Timing
`define REF_CLK_MHZ 50
`define LOCK_TIME_US 500
`define LOCK_CNT_W 20
`define POR_CYCLES 256
`define EXT_RST_CYCLES 256
`define SWRST_CYCLES 4
`define MIN_RATIO 2

`endif

/* pkg/pll_clock_and_reset_pkg.sv */
// Types shared by the PLL clock and reset unit
`default_nettype none
package pll_clock_and_reset_pkg;
    // Reset sequencer states
    typedef enum logic [2:0] {ST_POWER, ST_COUNT, ST_EXT, ST_RUN, ST_SOFT} rst_state_t;
    // One PLL's unpacked divider settings
    typedef struct packed {
        logic [1:0] output_divider;
        logic [4:0] r;
        logic [8:0] n;
    } pll_cfg_t;
endpackage
`default_nettype wire

/* design/pll_clock_and_reset_unit.sv */
// PLL divider model, reset sequencing and control registers
`include "pll_clock_and_reset_unit_consts.svh"
`default_nettype none
module pll_clock_and_reset_unit #(
    parameter int unsigned LOCK_CYCLES = `LOCK_TIME_US * `REF_CLK_MHZ
) (
    // Reference clock and block reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Power good and two-way reset pin
    input wire logic por_ok_i,
    input wire logic rst_pin_i,
    output logic rst_pin_o,
    output logic rst_pin_oe_o,
    // Register port
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic [7:0] status_o,
    // Resets and clocks to the core
    output logic core_rst_n_o,
    output logic sm_rst_n_o,
    output logic [2:0] pll_locked_o,
    output logic [2:0] pll_tick_o
);

    // Output ratio from code, zero for the unsupported code
    function automatic logic [2:0] out_div_ratio(input logic [1:0] code);
        case (code)
            2'h0: out_div_ratio = 3'h1;
            2'h1: out_div_ratio = 3'h2;
            2'h3: out_div_ratio = 3'h4;
            default: out_div_ratio = 3'h0; // see R05
        endcase
    endfunction

    // Unpack the two config bytes of one PLL
    function automatic pll_clock_and_reset_pkg::pll_cfg_t unpack(input logic [7:0] c1,
            input logic [7:0] c2);
        unpack.output_divider = c1[`CFG1_OUTDIV_HI:`CFG1_OUTDIV_LO];
        unpack.r = c1[`CFG1_R_HI:`CFG1_R_LO];
        unpack.n = {c1[`CFG1_N8_BIT], c2};
    endfunction

    // Byte address of a PLL's first or second config register
    function automatic logic [7:0] cfg_addr(input int p, input int second);
        cfg_addr = 8'(`ADDR_PIXEL_CFG1 + 2 * p + second);
    endfunction

    // Pin and power-good synchronisers, first stage feeds only the second
    logic [2:0] por_sync_q, por_sync_d, pin_sync_q, pin_sync_d;
    logic por_ok_q, por_ok_d, pin_q, pin_d;

    always_comb begin
        por_sync_d = {por_sync_q[1:0], por_ok_i};
        pin_sync_d = {pin_sync_q[1:0], rst_pin_i};
        // Accept a change only once stages two and three agree
        por_ok_d = (por_sync_q[1] == por_sync_q[2]) ? por_sync_q[2] : por_ok_q;
        pin_d = (pin_sync_q[1] == pin_sync_q[2]) ? pin_sync_q[2] : pin_q;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            por_sync_q <= 3'h0;
            pin_sync_q <= 3'h7;
            por_ok_q <= 1'b0;
            pin_q <= 1'b1;
        end else begin
            por_sync_q <= por_sync_d;
            pin_sync_q <= pin_sync_d;
            por_ok_q <= por_ok_d;
            pin_q <= pin_d;
        end
    end

    // Reset sequencer
    pll_clock_and_reset_pkg::rst_state_t state_q, state_d;
    logic [7:0] cnt_q, cnt_d, ext_cnt_q, ext_cnt_d;
    logic core_rst_n_q, core_rst_n_d, sm_rst_n_q, sm_rst_n_d, pin_oe_q, pin_oe_d;
    logic sw_start, ext_take, hard_rst, soft_done;

    assign ext_take = (state_q == pll_clock_and_reset_pkg::ST_RUN) && !pin_q
        && (ext_cnt_q == 8'(`EXT_RST_CYCLES - 1)); // see R10
    // A soft request that meets an accepted pin reset is dropped, the hard reset wins
    assign sw_start = reg_wr_i && (reg_addr_i == `ADDR_CTRL) && reg_wdata_i[`SWRST_BIT]
        && (state_q == pll_clock_and_reset_pkg::ST_RUN) && !ext_take; // see R12
    assign hard_rst = (state_q == pll_clock_and_reset_pkg::ST_POWER)
        || (state_q == pll_clock_and_reset_pkg::ST_COUNT)
        || (state_q == pll_clock_and_reset_pkg::ST_EXT);
    assign soft_done = (state_q == pll_clock_and_reset_pkg::ST_SOFT)
        && (cnt_q == 8'(`SWRST_CYCLES - 1));

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        // Low run length, only while running so our own drive is not counted
        ext_cnt_d = (state_q == pll_clock_and_reset_pkg::ST_RUN && !pin_q) ?
            ext_cnt_q + 8'h01 : 8'h00;
        if (!por_ok_q) begin
            state_d = pll_clock_and_reset_pkg::ST_POWER; // see R08
            cnt_d = 8'h00;
        end else begin
            case (state_q)
                pll_clock_and_reset_pkg::ST_POWER: begin
                    state_d = pll_clock_and_reset_pkg::ST_COUNT;
                    cnt_d = 8'h00;
                end
                pll_clock_and_reset_pkg::ST_COUNT: begin
                    if (cnt_q == 8'(`POR_CYCLES - 1)) begin
                        state_d = pll_clock_and_reset_pkg::ST_RUN; // see R08
                        cnt_d = 8'h00;
                    end else begin
                        cnt_d = cnt_q + 8'h01;
                    end
                end
                pll_clock_and_reset_pkg::ST_EXT: begin
                    // Held until the pin is released, then a full release delay
                    if (pin_q) begin
                        state_d = pll_clock_and_reset_pkg::ST_COUNT;
                        cnt_d = 8'h00;
                    end
                end
                pll_clock_and_reset_pkg::ST_RUN: begin
                    if (ext_take) begin
                        state_d = pll_clock_and_reset_pkg::ST_EXT; // see R10
                    end else if (sw_start) begin
                        state_d = pll_clock_and_reset_pkg::ST_SOFT; // see R12
                        cnt_d = 8'h00;
                    end
                end
                pll_clock_and_reset_pkg::ST_SOFT: begin
                    if (soft_done) begin
                        state_d = pll_clock_and_reset_pkg::ST_RUN;
                        cnt_d = 8'h00;
                    end else begin
                        cnt_d = cnt_q + 8'h01;
                    end
                end
                default: state_d = pll_clock_and_reset_pkg::ST_POWER;
            endcase
        end
        core_rst_n_d = (state_d == pll_clock_and_reset_pkg::ST_RUN)
            || (state_d == pll_clock_and_reset_pkg::ST_SOFT);
        sm_rst_n_d = (state_d == pll_clock_and_reset_pkg::ST_RUN); // see R13
        // Drive the pin low through the whole power-on sequence
        pin_oe_d = (state_d == pll_clock_and_reset_pkg::ST_POWER)
            || (state_d == pll_clock_and_reset_pkg::ST_COUNT); // see R09
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_q <= pll_clock_and_reset_pkg::ST_POWER;
            cnt_q <= 8'h00;
            ext_cnt_q <= 8'h00;
            core_rst_n_q <= 1'b0;
            sm_rst_n_q <= 1'b0;
            pin_oe_q <= 1'b1;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            ext_cnt_q <= ext_cnt_d;
            core_rst_n_q <= core_rst_n_d;
            sm_rst_n_q <= sm_rst_n_d;
            pin_oe_q <= pin_oe_d;
        end
    end

    // Control and PLL config registers; a soft reset leaves them alone
    logic soft_q, soft_d;
    logic [6:0] ctrl_hi_q, ctrl_hi_d;
    logic [7:0] cfg1_q [`PLL_COUNT];
    logic [7:0] cfg1_d [`PLL_COUNT];
    logic [7:0] cfg2_q [`PLL_COUNT];
    logic [7:0] cfg2_d [`PLL_COUNT];
    logic [2:0] cfg_wr;
    logic wr_ok;

    assign wr_ok = reg_wr_i && !hard_rst;

    always_comb begin
        soft_d = soft_q;
        ctrl_hi_d = ctrl_hi_q;
        if (sw_start) begin
            soft_d = 1'b1;
        end else if (soft_done) begin
            soft_d = 1'b0; // see R14
        end
        if (wr_ok && reg_addr_i == `ADDR_CTRL) begin
            ctrl_hi_d = reg_wdata_i[7:1];
        end
        for (int p = 0; p < `PLL_COUNT; p++) begin
            cfg1_d[p] = cfg1_q[p]; // see R13
            cfg2_d[p] = cfg2_q[p];
            cfg_wr[p] = wr_ok && (reg_addr_i == cfg_addr(p, 0) || reg_addr_i == cfg_addr(p, 1));
            if (wr_ok && reg_addr_i == cfg_addr(p, 0)) begin
                cfg1_d[p] = reg_wdata_i;
            end
            if (wr_ok && reg_addr_i == cfg_addr(p, 1)) begin
                cfg2_d[p] = reg_wdata_i;
            end
        end
    end

    // Hard resets restore defaults, the soft reset does not
    always_ff @(posedge clk_i) begin
        if (srst_i || hard_rst) begin
            soft_q <= 1'b0;
            ctrl_hi_q <= 7'(`CTRL_RST >> 1);
            for (int p = 0; p < `PLL_COUNT; p++) begin
                cfg1_q[p] <= `CFG1_RST;
                cfg2_q[p] <= `CFG2_RST;
            end
        end else begin
            soft_q <= soft_d;
            ctrl_hi_q <= ctrl_hi_d;
            cfg1_q <= cfg1_d;
            cfg2_q <= cfg2_d;
        end
    end

    // Per-PLL lock timer and rate model, each PLL on its own
    logic [`LOCK_CNT_W-1:0] lock_q [`PLL_COUNT];
    logic [`LOCK_CNT_W-1:0] lock_d [`PLL_COUNT];
    logic [9:0] acc_q [`PLL_COUNT];
    logic [9:0] acc_d [`PLL_COUNT];
    logic [2:0] locked, valid, tick_d, tick_q;

    always_comb begin
        for (int p = 0; p < `PLL_COUNT; p++) begin
            pll_clock_and_reset_pkg::pll_cfg_t c;
            logic [7:0] div;
            logic [10:0] sum;
            c = unpack(cfg1_q[p], cfg2_q[p]);
            div = 8'(c.r) * 8'(out_div_ratio(c.output_divider));
            sum = 11'(acc_q[p]) + 11'(c.n);
            valid[p] = (c.r >= 5'(`MIN_RATIO)) && (c.n >= 9'(`MIN_RATIO)) // see R03
                && (out_div_ratio(c.output_divider) != 3'h0); // see R05
            locked[p] = (lock_q[p] == `LOCK_CNT_W'(LOCK_CYCLES));
            // Timer restarts on power-up and on any change of this PLL
            if (hard_rst || cfg_wr[p]) begin
                lock_d[p] = '0; // see R15
            end else if (locked[p]) begin
                lock_d[p] = lock_q[p];
            end else begin
                lock_d[p] = lock_q[p] + `LOCK_CNT_W'(1);
            end
            // Phase accumulator: ticks at ref * n / (r * od), one per cycle at most
            tick_d[p] = 1'b0;
            acc_d[p] = 10'h000;
            if (valid[p] && locked[p]) begin
                if (sum >= 11'(div)) begin
                    tick_d[p] = 1'b1; // see R01
                    acc_d[p] = 10'(sum - 11'(div));
                    if (acc_d[p] >= 10'(div)) begin
                        acc_d[p] = 10'h000;
                    end
                end else begin
                    acc_d[p] = 10'(sum);
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            for (int p = 0; p < `PLL_COUNT; p++) begin
                lock_q[p] <= '0;
                acc_q[p] <= 10'h000;
            end
            tick_q <= 3'h0;
        end else begin
            lock_q <= lock_d; // see R06
            acc_q <= acc_d;
            tick_q <= tick_d;
        end
    end

    // Read data and status
    logic [7:0] rdata_q, rdata_d, status_q, status_d;

    always_comb begin
        rdata_d = 8'h00;
        if (reg_addr_i == `ADDR_CTRL) begin
            rdata_d = {ctrl_hi_q, soft_q};
        end
        for (int p = 0; p < `PLL_COUNT; p++) begin
            if (reg_addr_i == cfg_addr(p, 0)) begin
                rdata_d = cfg1_q[p];
            end
            if (reg_addr_i == cfg_addr(p, 1)) begin
                rdata_d = cfg2_q[p];
            end
        end
        status_d = 8'h00;
        status_d[`STS_SOFT_BIT] = soft_q;
        // Follows the next state, so it never outlives a reset or a config change
        status_d[`STS_NORMAL_BIT] = (state_d == pll_clock_and_reset_pkg::ST_RUN) && !hard_rst
            && (&locked) && !(|cfg_wr); // see R16
        status_d[`STS_CFGERR_BIT] = !(&valid);
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_q <= 8'h00;
            status_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
            status_q <= status_d;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign status_o = status_q;
    assign core_rst_n_o = core_rst_n_q;
    assign sm_rst_n_o = sm_rst_n_q;
    assign rst_pin_o = 1'b0; // Open-drain style: only ever pulls low
    assign rst_pin_oe_o = pin_oe_q;
    assign pll_locked_o = locked;
    assign pll_tick_o = tick_q;

    // Checks
    sequence s_count_entry;
        $rose(state_q == pll_clock_and_reset_pkg::ST_COUNT);
    endsequence

    property p_por_release;
        @(posedge clk_i) disable iff (srst_i || !por_ok_q)
        s_count_entry |-> ##255 !core_rst_n_o ##1 core_rst_n_o;
    endproperty
    a_por_release: assert property (p_por_release) else $error("reset release off"); // see R08

    property p_pin_drive;
        @(posedge clk_i) disable iff (srst_i)
        rst_pin_oe_o |-> (!rst_pin_o && !core_rst_n_o);
    endproperty
    a_pin_drive: assert property (p_pin_drive) else $error("pin driven outside reset"); // see R09

    property p_ext_accept;
        @(posedge clk_i) disable iff (srst_i)
        $rose(state_q == pll_clock_and_reset_pkg::ST_EXT)
            |-> $past(ext_cnt_q) == 8'(`EXT_RST_CYCLES - 1);
    endproperty
    a_ext_accept: assert property (p_ext_accept) else $error("short reset taken"); // see R10

    property p_soft_start;
        @(posedge clk_i) disable iff (srst_i || !por_ok_q)
        sw_start |=> (!sm_rst_n_o && core_rst_n_o && soft_q);
    endproperty
    a_soft_start: assert property (p_soft_start) else $error("soft reset missing"); // see R12

    property p_regs_kept;
        @(posedge clk_i) disable iff (srst_i)
        (state_q == pll_clock_and_reset_pkg::ST_SOFT)
            |=> $stable({cfg1_q[0], cfg1_q[1], cfg1_q[2], cfg2_q[0], cfg2_q[1], cfg2_q[2]});
    endproperty
    a_regs_kept: assert property (p_regs_kept) else $error("regs changed in soft reset"); // see R13

    sequence s_soft_busy;
        soft_q [*4] ##1 !soft_q;
    endsequence

    property p_soft_clear;
        @(posedge clk_i) disable iff (srst_i || !por_ok_q)
        $rose(soft_q) |-> s_soft_busy;
    endproperty
    a_soft_clear: assert property (p_soft_clear) else $error("soft bit clear wrong"); // see R14

    property p_relock;
        @(posedge clk_i) disable iff (srst_i)
        (|cfg_wr) |=> ((pll_locked_o & $past(cfg_wr)) == 3'h0)
            ##1 ((pll_tick_o & $past(cfg_wr, 2)) == 3'h0);
    endproperty
    a_relock: assert property (p_relock) else $error("lock kept after change"); // see R15

    property p_normal;
        @(posedge clk_i) disable iff (srst_i)
        status_o[`STS_NORMAL_BIT] |-> ((&pll_locked_o) && core_rst_n_o && sm_rst_n_o);
    endproperty
    a_normal: assert property (p_normal) else $error("normal before lock"); // see R16

    property p_invalid_idle;
        @(posedge clk_i) disable iff (srst_i)
        !valid[`PLL_ENGINE] |=> !pll_tick_o[`PLL_ENGINE];
    endproperty
    a_invalid_idle: assert property (p_invalid_idle) else $error("bad config ticks"); // see R05

endmodule
`default_nettype wire

/* tb/reset_source_model.sv */
// Host-side reset source and pull-up on the shared reset pin
`default_nettype none
module reset_source_model (
    // Clock and pull request
    input wire logic clk_i,
    input wire logic start_i,
    input wire logic [15:0] low_len_i,
    // Device drive on the pin
    input wire logic dev_oe_i,
    input wire logic dev_level_i,
    // Resolved pin level
    output logic pin_o,
    output logic busy_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] left_q = 16'h0000;
    logic [15:0] left_d;
    // Low time counts down; the bench picks long or noise-short pulses
    always_comb begin
        left_d = left_q;
        if (start_i) begin
            left_d = low_len_i;
        end else if (left_q != 16'h0000) begin
            left_d = left_q - 16'h0001;
        end
    end
    always_ff @(posedge clk_i) begin
        left_q <= left_d;
    end
    // Open drain with pull-up: either party pulling low wins
    assign pin_o = (left_q != 16'h0000 || (dev_oe_i && !dev_level_i)) ? 1'b0 : 1'b1;
    assign busy_o = (left_q != 16'h0000);
endmodule
`default_nettype wire

/* tb/pll_clock_and_reset_unit_bench.sv */
// Self-checking bench for the PLL clock and reset unit
`include "pll_clock_and_reset_unit_consts.svh"
`default_nettype none
module pll_clock_and_reset_unit_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LOCK = 20;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic por_ok_i = 1'b0;
    logic reg_wr_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic pull_start = 1'b0;
    logic [15:0] low_len = 16'h0000;
    logic pin_level, pull_busy, rst_pin_o, rst_pin_oe_o, core_rst_n_o, sm_rst_n_o;
    logic [7:0] reg_rdata_o, status_o;
    logic [2:0] pll_locked_o, pll_tick_o;
    int fail_count = 0;
    int total_checks = 0;
    int oe_cycles = 0;
    logic [31:0] seed = 32'h00015909;
    logic [7:0] regs_m [0:15];
    logic [15:0] fixed_cfg [0:4] = '{16'hFFFF, 16'h0402, 16'h020A, 16'h940A, 16'h1401};

    pll_clock_and_reset_unit #(.LOCK_CYCLES(LOCK)) uut (
        .clk_i(clk_i), .srst_i(srst_i), .por_ok_i(por_ok_i), .rst_pin_i(pin_level),
        .rst_pin_o(rst_pin_o), .rst_pin_oe_o(rst_pin_oe_o), .reg_wr_i(reg_wr_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .status_o(status_o), .core_rst_n_o(core_rst_n_o), .sm_rst_n_o(sm_rst_n_o),
        .pll_locked_o(pll_locked_o), .pll_tick_o(pll_tick_o));
    reset_source_model host (
        .clk_i(clk_i), .start_i(pull_start), .low_len_i(low_len), .dev_oe_i(rst_pin_oe_o),
        .dev_level_i(rst_pin_o), .pin_o(pin_level), .busy_o(pull_busy));

    // Clock at 50 MHz
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    // Cycles in which the device itself holds the pin low
    always @(posedge clk_i) begin
        if (rst_pin_oe_o === 1'b1 && pin_level === 1'b0) oe_cycles++;
    end

    function automatic logic [31:0] next_rand();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask
    // Hard reset brings every register back to its chosen reset value
    task automatic model_reset();
        for (int a = 0; a < 16; a++) regs_m[a] = 8'h00;
        for (int p = 0; p < 3; p++) begin
            regs_m[5 + 2 * p] = `CFG1_RST;
            regs_m[6 + 2 * p] = `CFG2_RST;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
        if (a >= 8'h05 && a <= 8'h0A) regs_m[a] = d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        @(posedge clk_i);
        #1;
        d = reg_rdata_o;
    endtask
    // Bounded wait: 0 core reset, 1 normal status, 2 lock of PLL p
    task automatic wait_bit(input int sel, input int p, input logic val, input int limit,
                            output int cyc);
        logic b;
        for (cyc = 1; cyc <= limit; cyc++) begin
            @(posedge clk_i);
            #1;
            b = (sel == 0) ? core_rst_n_o : (sel == 1) ? status_o[1] : pll_locked_o[p];
            if (b === val) return;
        end
        check(1'b0, 1'b1, "wait ran out");
        finish_test();
    endtask
    task automatic compare_all();
        logic [7:0] d;
        for (int a = 0; a < 12; a++) begin
            rd(a[7:0], d);
            check(d, regs_m[a], "register readback");
        end
    endtask
    // Program one PLL and measure its tick rate against the ratio formula
    task automatic pll_trial(input int p, input logic [7:0] c1, input logic [7:0] c2);
        int r, n, odv, ex, cnt, cyc;
        logic ok;
        r = c1[5:1];
        n = {c1[0], c2};
        odv = (c1[7:6] == 2'b00) ? 1 : (c1[7:6] == 2'b01) ? 2 : (c1[7:6] == 2'b11) ? 4 : 0;
        ok = (r >= 2 && n >= 2 && odv != 0);
        wr(8'(5 + 2 * p), c1);
        #1;
        check(pll_locked_o[p], 1'b0, "lock after change");
        check(pll_locked_o & ~(3'b001 << p), 3'b111 & ~(3'b001 << p), "other plls");
        wr(8'(6 + 2 * p), c2);
        if (ok) wait_bit(2, p, 1'b1, LOCK + 20, cyc);
        else repeat (LOCK + 5) @(posedge clk_i);
        #1;
        check(status_o[2], !ok, "config error flag");
        cnt = 0;
        repeat (256) begin
            @(posedge clk_i);
            #1;
            cnt += pll_tick_o[p];
        end
        ex = ok ? 256 * n / (r * odv) : 0;
        if (ex > 256) ex = 256;
        check(cnt + 2 >= ex && cnt <= ex + 2, 1'b1, "tick rate");
    endtask

    initial begin
        int cyc, lows, busy;
        logic [31:0] x;
        logic [7:0] c1;
        model_reset();
        repeat (3) @(posedge clk_i);
        srst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        por_ok_i <= 1'b1;
        #1;
        oe_cycles = 0;
        wait_bit(0, 0, 1'b1, 400, cyc);
        check(cyc >= `POR_CYCLES && cyc <= `POR_CYCLES + 8, 1'b1, "power-on length");
        check(oe_cycles >= `POR_CYCLES, 1'b1, "pin driven in power-on");
        check(status_o[1], 1'b0, "normal before lock");
        wait_bit(1, 0, 1'b1, LOCK + 40, cyc);
        check(cyc >= LOCK - 2, 1'b1, "lock time honoured");
        check(rst_pin_oe_o, 1'b0, "pin released");
        check(rst_pin_o, 1'b0, "pin drive level");
        wr(8'h0B, 8'hA5);
        compare_all();
        for (int p = 0; p < 3; p++) begin
            for (int k = 0; k < 5; k++) pll_trial(p, fixed_cfg[k][15:8], fixed_cfg[k][7:0]);
            for (int k = 0; k < 2; k++) begin
                x = next_rand();
                c1 = {(x[1:0] == 2'b10) ? 2'b11 : x[1:0], 5'(2 + x[7:3] % 30), 1'b0};
                pll_trial(p, c1, 8'(2 + x[15:8] % (2 * c1[5:1])));
            end
        end
        // Legal clock plan: memory between engine and twice engine, engine over 1.5x pixel
        pll_trial(0, 8'hD4, 8'h0A);
        pll_trial(2, 8'hD4, 8'h14);
        pll_trial(1, 8'hD4, 8'h1E);
        compare_all();
        // Soft reset: bit reads busy, then clears itself; registers keep values
        wr(`ADDR_CTRL, 8'h01);
        busy = 0;
        lows = 0;
        repeat (20) begin
            @(posedge clk_i);
            #1;
            busy += reg_rdata_o[0] + status_o[0];
            lows += !sm_rst_n_o;
        end
        check(busy, 2 * `SWRST_CYCLES, "soft reset bit busy");
        check(reg_rdata_o[0], 1'b0, "soft reset bit cleared");
        check(lows > 0 && core_rst_n_o === 1'b1, 1'b1, "state machines only");
        compare_all();
        // Noise-short low on the pin is ignored
        @(posedge clk_i);
        low_len <= 16'h0064;
        pull_start <= 1'b1;
        @(posedge clk_i);
        pull_start <= 1'b0;
        lows = 0;
        repeat (140) begin
            @(posedge clk_i);
            #1;
            lows += !core_rst_n_o;
        end
        check(lows, 0, "short pulse ignored");
        // Long low on the pin resets the unit
        @(posedge clk_i);
        low_len <= 16'h012C;
        pull_start <= 1'b1;
        @(posedge clk_i);
        pull_start <= 1'b0;
        wait_bit(0, 0, 1'b0, 320, cyc);
        check(cyc >= 250, 1'b1, "external reset delay");
        #1;
        oe_cycles = 0;
        wait_bit(0, 0, 1'b1, 700, cyc);
        check(oe_cycles >= `POR_CYCLES, 1'b1, "pin driven after external reset");
        model_reset();
        wait_bit(1, 0, 1'b1, LOCK + 40, cyc);
        compare_all();
        finish_test();
    end
endmodule
`default_nettype wire
